// >>> shared/etc_consts.svh
`ifndef ETC_CONSTS_SVH
`define ETC_CONSTS_SVH
// count limits
`define ETC_BOTTOM       8'h00
`define ETC_MAX          8'hFF
// clock source select codes
`define ETC_CS_STOP      3'h0
`define ETC_CS_DIV1      3'h1
`define ETC_CS_DIV8      3'h2
`define ETC_CS_DIV64     3'h3
`define ETC_CS_DIV256    3'h4
`define ETC_CS_DIV1024   3'h5
`define ETC_CS_EXT_FALL  3'h6
`define ETC_CS_EXT_RISE  3'h7
// prescaler terminal counts (divide minus one)
`define ETC_PS_DIV8      10'h007
`define ETC_PS_DIV64     10'h03F
`define ETC_PS_DIV256    10'h0FF
`define ETC_PS_DIV1024   10'h3FF
// flag and mask bit positions
`define ETC_BIT_OVF      0
`define ETC_BIT_MATCH_A  1
`define ETC_BIT_MATCH_B  2
// reset values
`define ETC_RST_BYTE     8'h00
`define ETC_RST_FLAGS    3'h0
`endif

// >>> shared/etc_pkg.sv
package etc_pkg;
  // waveform generation modes
  typedef enum logic [2:0] {
    ETC_NORMAL,
    ETC_PWM_PC_MAX,
    ETC_CTC,
    ETC_PWM_FAST_MAX,
    ETC_RSVD4,
    ETC_PWM_PC_OCA,
    ETC_RSVD6,
    ETC_PWM_FAST_OCA
  } etc_mode_t;
  // compare output action per unit
  typedef enum logic [1:0] {
    ETC_OUT_OFF,
    ETC_OUT_TOGGLE,
    ETC_OUT_CLEAR,
    ETC_OUT_SET
  } etc_out_t;
  // processor write strobes with data
  typedef struct packed {
    logic       countWr;
    logic       cmpAWr;
    logic       cmpBWr;
    logic [7:0] data;
  } etc_wr_t;
  // three interrupt sources, bit order ovf, a, b
  typedef struct packed {
    logic matchB;
    logic matchA;
    logic ovf;
  } etc_flags_t;
endpackage : etc_pkg

// >>> hw/etc_timer.sv
`timescale 1ns/1ps
`include "etc_consts.svh"
// Behaviour
// - counter and both compare values are 8-bit
// - floor reached when count equals 0x00
// - ceiling reached when count equals 0xFF
// - peak is 0xFF or compare_value_a by mode
// - flags readable ungated, each interrupt request gated by its mask bit
// - three sources: overflow, match a, match b
// - tick from prescaled clock or external edge
// - no source selected means counter stays idle
// - continuous compare sets match flag per unit
// - compare values double-buffered in pwm modes, updated in sequence
// - waveform generator drives both compare outputs
// - clock_source_select alone chooses tick source; timerPowerOff also forces the tick low
// - count write beats tick clear or count
// - match flag sets one tick after equality
// - flags clear on service or write one
// - count write blocks compares next tick
module etc_timer
  import etc_pkg::*;
(
  // clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // control
  input  wire logic       timerPowerOff,
  input  wire logic [2:0] clockSourceSelect,
  input  wire etc_mode_t  waveMode,
  input  wire etc_out_t   outModeA,
  input  wire etc_out_t   outModeB,
  // processor writes
  input  wire etc_wr_t    wr,
  input  wire etc_flags_t flagClearWr,
  input  wire etc_flags_t intAck,
  input  wire etc_flags_t timerMaskReg,
  // pin
  input  wire logic       externalCountInput,
  // status
  output logic [7:0]      timerCount,
  output logic [7:0]      compareValueA,
  output logic [7:0]      compareValueB,
  output etc_flags_t      timerFlagReg,
  output etc_flags_t      intReq,
  output logic            compareOutputA,
  output logic            compareOutputB
);
  // state registers
  logic [7:0]  count_ff, nxt_count;       // counter value
  logic [7:0]  cmpA_ff, nxt_cmpA;         // active compare a
  logic [7:0]  cmpB_ff, nxt_cmpB;         // active compare b
  logic [7:0]  bufA_ff, nxt_bufA;         // compare a buffer
  logic [7:0]  bufB_ff, nxt_bufB;         // compare b buffer
  logic        down_ff, nxt_down;         // phase correct direction
  etc_flags_t  flags_ff, nxt_flags;       // sticky flags
  logic        matchA_ff, nxt_matchA;     // pending match a
  logic        matchB_ff, nxt_matchB;     // pending match b
  logic        block_ff, nxt_block;       // compare blocking after write
  logic        ocA_ff, nxt_ocA;           // output a state
  logic        ocB_ff, nxt_ocB;           // output b state
  logic [9:0]  ps_ff, nxt_ps;             // prescaler
  logic        ext1_ff, ext2_ff, ext3_ff; // pin sync and edge history
  // combinational helpers
  logic        tick;                      // timer tick enable
  logic [7:0]  peak;                      // sequence peak
  logic        isPwm, isPc, buffered;
  logic        atFloor, atCeil, atPeak;

  // mode decode used by several paths
  function automatic logic mode_pwm(input etc_mode_t m);
    return (m != ETC_NORMAL) && (m != ETC_CTC) &&
           (m != ETC_RSVD4) && (m != ETC_RSVD6);
  endfunction : mode_pwm

  // apply compare output action to an output state
  function automatic logic out_act(input etc_out_t a, input logic cur);
    unique case (a)
      ETC_OUT_OFF:    return cur;
      ETC_OUT_TOGGLE: return ~cur;
      ETC_OUT_CLEAR:  return 1'b0;
      ETC_OUT_SET:    return 1'b1;
    endcase
  endfunction : out_act

  // pin synchroniser, third stage only feeds edge detect
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ext1_ff <= 1'b0;
      ext2_ff <= 1'b0;
      ext3_ff <= 1'b0;
    end
    else
    begin
      ext1_ff <= externalCountInput;
      ext2_ff <= ext1_ff;
      ext3_ff <= ext2_ff;
    end
  end

  // tick selection and prescaler
  always_comb
  begin
    nxt_ps = (clockSourceSelect == `ETC_CS_STOP || timerPowerOff) ?
             10'h000 : ps_ff + 10'h001;
    tick   = 1'b0;
    unique case (clockSourceSelect)
      `ETC_CS_STOP:     tick = 1'b0;
      `ETC_CS_DIV1:     tick = 1'b1;
      `ETC_CS_DIV8:     tick = (ps_ff[2:0] == 3'(`ETC_PS_DIV8));
      `ETC_CS_DIV64:    tick = (ps_ff[5:0] == 6'(`ETC_PS_DIV64));
      `ETC_CS_DIV256:   tick = (ps_ff[7:0] == 8'(`ETC_PS_DIV256));
      `ETC_CS_DIV1024:  tick = (ps_ff == `ETC_PS_DIV1024);
      `ETC_CS_EXT_FALL: tick = ext3_ff & ~ext2_ff;
      `ETC_CS_EXT_RISE: tick = ~ext3_ff & ext2_ff;
    endcase
    if (timerPowerOff)
      tick = 1'b0;
  end

  // sequence limits
  always_comb
  begin
    isPwm    = mode_pwm(waveMode);
    isPc     = (waveMode == ETC_PWM_PC_MAX) ||
               (waveMode == ETC_PWM_PC_OCA);
    buffered = isPwm;
    peak     = (waveMode == ETC_CTC || waveMode == ETC_PWM_PC_OCA ||
                waveMode == ETC_PWM_FAST_OCA) ? cmpA_ff : `ETC_MAX;
    atFloor  = (count_ff == `ETC_BOTTOM);
    atCeil   = (count_ff == `ETC_MAX);
    atPeak   = (count_ff == peak);
  end

  // counter, compare, flag and waveform next state
  always_comb
  begin
    nxt_count  = count_ff;
    nxt_down   = down_ff;
    nxt_bufA   = bufA_ff;
    nxt_bufB   = bufB_ff;
    nxt_cmpA   = cmpA_ff;
    nxt_cmpB   = cmpB_ff;
    nxt_flags  = flags_ff;
    nxt_matchA = matchA_ff;
    nxt_matchB = matchB_ff;
    nxt_block  = block_ff;
    nxt_ocA    = ocA_ff;
    nxt_ocB    = ocB_ff;
    // software writes: buffer in pwm modes, direct otherwise
    if (wr.cmpAWr)
    begin
      nxt_bufA = wr.data;
      if (!buffered)
        nxt_cmpA = wr.data;
    end
    if (wr.cmpBWr)
    begin
      nxt_bufB = wr.data;
      if (!buffered)
        nxt_cmpB = wr.data;
    end
    // clearing: write one or service, then hardware sets win
    nxt_flags = nxt_flags & ~(flagClearWr | intAck);
    if (tick)
    begin
      // equality seen last tick raises its flag now
      if (matchA_ff)
        nxt_flags.matchA = 1'b1;
      if (matchB_ff)
        nxt_flags.matchB = 1'b1;
      // compare on this tick unless blocked by a count write
      nxt_matchA = !block_ff && (count_ff == cmpA_ff);
      nxt_matchB = !block_ff && (count_ff == cmpB_ff);
      nxt_block  = 1'b0;
      if (nxt_matchA && !isPwm)
        nxt_ocA = out_act(outModeA, ocA_ff);
      if (nxt_matchB && !isPwm)
        nxt_ocB = out_act(outModeB, ocB_ff);
      // count sequence per mode
      if (isPc)
      begin
        if (!down_ff && atPeak)
        begin
          nxt_down  = 1'b1;
          nxt_count = count_ff - 8'h01;
          nxt_cmpA  = bufA_ff;
          nxt_cmpB  = bufB_ff;
        end
        else if (down_ff && atFloor)
        begin
          nxt_down        = 1'b0;
          nxt_count       = count_ff + 8'h01;
          nxt_flags.ovf   = 1'b1;
        end
        else
          nxt_count = down_ff ? count_ff - 8'h01 : count_ff + 8'h01;
      end
      // reserved modes fall through and count like normal mode
      else if (atPeak && (isPwm || waveMode == ETC_CTC))
      begin
        nxt_count = `ETC_BOTTOM;
        if (isPwm)
        begin
          nxt_flags.ovf = 1'b1;
          nxt_cmpA      = bufA_ff;
          nxt_cmpB      = bufB_ff;
        end
      end
      else
      begin
        nxt_count = count_ff + 8'h01;
        if (atCeil)
          nxt_flags.ovf = 1'b1;
      end
    end
    // processor count write overrides the tick's count and block update; tick flag and output actions still apply
    if (wr.countWr)
    begin
      nxt_count = wr.data;
      nxt_block = 1'b1;
    end
  end

  // register all state
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      count_ff  <= `ETC_RST_BYTE;
      cmpA_ff   <= `ETC_RST_BYTE;
      cmpB_ff   <= `ETC_RST_BYTE;
      bufA_ff   <= `ETC_RST_BYTE;
      bufB_ff   <= `ETC_RST_BYTE;
      down_ff   <= 1'b0;
      flags_ff  <= `ETC_RST_FLAGS;
      matchA_ff <= 1'b0;
      matchB_ff <= 1'b0;
      block_ff  <= 1'b0;
      ocA_ff    <= 1'b0;
      ocB_ff    <= 1'b0;
      ps_ff     <= 10'h000;
    end
    else
    begin
      count_ff  <= nxt_count;
      cmpA_ff   <= nxt_cmpA;
      cmpB_ff   <= nxt_cmpB;
      bufA_ff   <= nxt_bufA;
      bufB_ff   <= nxt_bufB;
      down_ff   <= nxt_down;
      flags_ff  <= nxt_flags;
      matchA_ff <= nxt_matchA;
      matchB_ff <= nxt_matchB;
      block_ff  <= nxt_block;
      ocA_ff    <= nxt_ocA;
      ocB_ff    <= nxt_ocB;
      ps_ff     <= nxt_ps;
    end
  end

  // pwm outputs are compare-derived levels, others from state
  always_comb
  begin
    timerCount    = count_ff;
    compareValueA = buffered ? bufA_ff : cmpA_ff;
    compareValueB = buffered ? bufB_ff : cmpB_ff;
    timerFlagReg  = flags_ff;
    intReq        = flags_ff & timerMaskReg;
    compareOutputA = isPwm ? (outModeA == ETC_OUT_CLEAR ?
                     (count_ff < cmpA_ff) : (outModeA == ETC_OUT_SET ?
                     (count_ff >= cmpA_ff) : 1'b0)) : ocA_ff;
    compareOutputB = isPwm ? (outModeB == ETC_OUT_CLEAR ?
                     (count_ff < cmpB_ff) : (outModeB == ETC_OUT_SET ?
                     (count_ff >= cmpB_ff) : 1'b0)) : ocB_ff;
  end

  // a count write followed directly by a tick
  sequence s_write_then_tick;
    wr.countWr ##1 (!wr.countWr && tick);
  endsequence : s_write_then_tick

  // stopped source never moves the counter without a write
  chk_stop_idle: assert property (@(posedge clock) disable iff (srst)
    (clockSourceSelect == `ETC_CS_STOP && !wr.countWr)
      |=> $stable(count_ff))
    else $error("counter moved with no clock source");
  // count write wins over tick
  chk_write_wins: assert property (@(posedge clock) disable iff (srst)
    wr.countWr |=> count_ff == $past(wr.data))
    else $error("count write lost");
  // write blocks compare on following tick
  chk_block_match: assert property (@(posedge clock) disable iff (srst)
    s_write_then_tick |=> !matchA_ff && !matchB_ff)
    else $error("compare not blocked after count write");
  // pending match raises flag at next tick
  chk_flag_delay: assert property (@(posedge clock) disable iff (srst)
    (matchA_ff && tick) |=> flags_ff.matchA)
    else $error("match flag a not set one tick later");
  // interrupt gating
  chk_int_gate: assert property (@(posedge clock) disable iff (srst)
    intReq == (timerFlagReg & timerMaskReg))
    else $error("interrupt not gated by mask");
  // write one clears absent a set
  chk_flag_clear: assert property (@(posedge clock) disable iff (srst)
    (flagClearWr.ovf && !tick) |=> !flags_ff.ovf)
    else $error("overflow flag not cleared");
  // normal mode wraps max to floor with overflow
  chk_ovf_wrap: assert property (@(posedge clock) disable iff (srst)
    (waveMode == ETC_NORMAL && tick && atCeil && !wr.countWr)
      |=> count_ff == `ETC_BOTTOM && flags_ff.ovf)
    else $error("overflow wrap wrong");
  // power off keeps tick low
  chk_power_off: assert property (@(posedge clock)
    disable iff (srst) timerPowerOff |-> !tick)
    else $error("tick while powered off");
endmodule : etc_timer

// >>> verif/etc_pin_model.sv
`timescale 1ns/1ps
// far side: drives the count pin, watches both compare pins
module etc_pin_model (
  // clock
  input  wire logic clock,
  // pins
  output logic      externalCountInput,
  input  wire logic compareOutputA,
  input  wire logic compareOutputB
);
  int   risesA; // rising edges seen on compare pin a
  int   risesB; // rising edges seen on compare pin b
  logic lastA;  // pin a one clock ago
  logic lastB;  // pin b one clock ago

  // pin idles low, counters start empty
  initial
  begin
    externalCountInput = 1'b0;
    risesA = 0;
    risesB = 0;
    lastA = 1'b0;
    lastB = 1'b0;
  end

  // count rising edges of the compare pins
  always @(posedge clock)
  begin
    lastA <= compareOutputA;
    lastB <= compareOutputB;
    if (compareOutputA && !lastA)
      risesA++;
    if (compareOutputB && !lastB)
      risesB++;
  end

  // slow pulses, three clocks high and low, so the synchroniser sees each
  task pulses(input int n);
    repeat (n)
    begin
      repeat (3) @(posedge clock);
      externalCountInput <= 1'b1;
      repeat (3) @(posedge clock);
      externalCountInput <= 1'b0;
    end
  endtask : pulses
endmodule : etc_pin_model

// >>> verif/tb_top.sv
`timescale 1ns/1ps
// directed bench for the timer through its plain control ports
module tb_top
  import etc_pkg::*;
;
  localparam int         LIMIT  = 5000; // timeout in clocks
  localparam logic [2:0] WR_CNT = 3'h4; // count write strobe
  localparam logic [2:0] WR_CA  = 3'h2; // compare a write strobe
  localparam logic [2:0] WR_CB  = 3'h1; // compare b write strobe
  // design inputs
  logic       clock;
  logic       srst;
  logic       timerPowerOff;
  logic [2:0] cs;
  etc_mode_t  waveMode;
  etc_out_t   outModeA;
  etc_out_t   outModeB;
  etc_wr_t    wr;
  etc_flags_t flagClr;
  etc_flags_t intAck;
  etc_flags_t mask;
  logic       extPin;
  // design outputs
  logic [7:0] timerCount;
  logic [7:0] cmpA;
  logic [7:0] cmpB;
  etc_flags_t flags;
  etc_flags_t intReq;
  logic       outA;
  logic       outB;
  // bookkeeping
  int         errTotal;
  int         totalChecks;
  int         cycles;
  logic [7:0] peak;

  etc_timer i_dut (.clock(clock), .srst(srst),
    .timerPowerOff(timerPowerOff), .clockSourceSelect(cs),
    .waveMode(waveMode), .outModeA(outModeA), .outModeB(outModeB),
    .wr(wr), .flagClearWr(flagClr), .intAck(intAck), .timerMaskReg(mask),
    .externalCountInput(extPin), .timerCount(timerCount),
    .compareValueA(cmpA), .compareValueB(cmpB), .timerFlagReg(flags),
    .intReq(intReq), .compareOutputA(outA), .compareOutputB(outB));

  etc_pin_model i_pin (.clock(clock), .externalCountInput(extPin),
    .compareOutputA(outA), .compareOutputB(outB));

  // 50 MHz clock
  initial
    clock = 1'b0;
  always #10 clock = ~clock;

  // hang guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      errTotal++;
      summarize();
    end
  end

  // compare one byte
  task chk(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk

  // let clocks pass, then sample settled outputs
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  // one-cycle processor write strobe
  task wrReg(input logic [2:0] k, input logic [7:0] d);
    @(posedge clock);
    wr <= {k, d};
    @(posedge clock);
    wr <= '0;
    #1;
  endtask : wrReg

  // wait for a count value under a bound
  task waitCount(input logic [7:0] v);
    int n;
    n = 0;
    while (timerCount !== v && n < 600)
    begin
      tick(1);
      n++;
    end
    chk(timerCount, v);
  endtask : waitCount

  // print counts and verdict, end the run
  task summarize();
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // main sequence
  initial
  begin
    errTotal = 0;
    totalChecks = 0;
    cycles = 0;
    srst = 1'b1;
    timerPowerOff = 1'b0;
    cs = 3'h0;
    waveMode = ETC_NORMAL;
    outModeA = ETC_OUT_OFF;
    outModeB = ETC_OUT_OFF;
    wr = '0;
    flagClr = '0;
    intAck = '0;
    mask = 3'h7;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    tick(1);
    // reset state
    chk(timerCount, 8'h00);
    chk(cmpA, 8'h00);
    chk(cmpB, 8'h00);
    chk({5'h00, flags}, 8'h00);
    chk({6'h00, outB, outA}, 8'h00);
    // stopped and powered-off counter holds
    wrReg(WR_CNT, 8'h10);
    tick(5);
    chk(timerCount, 8'h10);
    @(posedge clock) cs <= 3'h1;
    timerPowerOff <= 1'b1;
    tick(5);
    chk(timerCount, 8'h10);
    @(posedge clock) timerPowerOff <= 1'b0;
    // write beats the running tick
    wrReg(WR_CNT, 8'h40);
    chk(timerCount, 8'h40);
    // matches on both units, flag one tick late, toggle output
    @(posedge clock) cs <= 3'h0;
    outModeA <= ETC_OUT_TOGGLE;
    outModeB <= ETC_OUT_TOGGLE;
    wrReg(WR_CA, 8'h20);
    wrReg(WR_CB, 8'h22);
    chk(cmpA, 8'h20);
    chk(cmpB, 8'h22);
    wrReg(WR_CNT, 8'h1C);
    @(posedge clock) cs <= 3'h1;
    waitCount(8'h21);
    chk({7'h00, flags.matchA}, 8'h00);
    tick(1);
    chk({7'h00, flags.matchA}, 8'h01);
    waitCount(8'h28);
    chk({5'h00, flags}, 8'h06);
    chk({5'h00, intReq}, 8'h06);
    chk({7'h00, outA}, 8'h01);
    chk(i_pin.risesA[7:0], 8'h01);
    chk({7'h00, outB}, 8'h01);
    chk(i_pin.risesB[7:0], 8'h01);
    @(posedge clock) mask <= 3'h1;
    tick(1);
    chk({5'h00, intReq}, 8'h00);
    // write one clears, zero bits leave flags alone, service clears
    @(posedge clock) cs <= 3'h0;
    flagClr <= 3'h2;
    @(posedge clock) flagClr <= 3'h0;
    tick(1);
    chk({5'h00, flags}, 8'h04);
    @(posedge clock) intAck <= 3'h4;
    @(posedge clock) intAck <= 3'h0;
    tick(1);
    chk({5'h00, flags}, 8'h00);
    // count write equal to compare a blocks that match
    wrReg(WR_CNT, 8'h20);
    @(posedge clock) cs <= 3'h1;
    waitCount(8'h26);
    chk({5'h00, flags}, 8'h04);
    // wrap from ceiling to floor sets overflow only
    @(posedge clock) cs <= 3'h0;
    flagClr <= 3'h7;
    @(posedge clock) flagClr <= 3'h0;
    wrReg(WR_CNT, 8'hFD);
    @(posedge clock) cs <= 3'h1;
    waitCount(8'h00);
    waitCount(8'h02);
    chk({5'h00, flags}, 8'h01);
    // clear on compare a caps the sequence
    @(posedge clock) cs <= 3'h0;
    waveMode <= ETC_CTC;
    wrReg(WR_CA, 8'h10);
    wrReg(WR_CNT, 8'h00);
    @(posedge clock) cs <= 3'h1;
    peak = 8'h00;
    repeat (60)
    begin
      tick(1);
      if (timerCount > peak)
        peak = timerCount;
    end
    chk(peak, 8'h10);
    // external pin, rising then falling edges
    @(posedge clock) cs <= 3'h0;
    waveMode <= ETC_NORMAL;
    wrReg(WR_CNT, 8'h00);
    @(posedge clock) cs <= 3'h7;
    i_pin.pulses(4);
    tick(8);
    chk(timerCount, 8'h04);
    @(posedge clock) cs <= 3'h6;
    i_pin.pulses(3);
    tick(8);
    chk(timerCount, 8'h07);
    // pwm compare write waits in buffer until top
    @(posedge clock) cs <= 3'h0;
    wrReg(WR_CA, 8'h08);
    @(posedge clock) waveMode <= ETC_PWM_FAST_MAX;
    outModeA <= ETC_OUT_CLEAR;
    wrReg(WR_CNT, 8'h40);
    wrReg(WR_CA, 8'h80);
    chk(cmpA, 8'h80);
    tick(2);
    chk({7'h00, outA}, 8'h00);
    @(posedge clock) cs <= 3'h1;
    waitCount(8'h05);
    @(posedge clock) cs <= 3'h0;
    wrReg(WR_CNT, 8'h40);
    tick(2);
    chk({7'h00, outA}, 8'h01);
    summarize();
  end
endmodule : tb_top
